// File: inc/acb_nv_if.sv
// Lookup path between the control logic and the signature and customer byte store
`timescale 1ns/1ps
`default_nettype none
interface acb_nv_if;
  import acb_pkg::*;
  logic      rd;
  acb_addr_t addr;
  acb_byte_t rdata;
  logic      hit;
  modport store (input rd, input addr, output rdata, output hit);
  modport user  (output rd, output addr, input rdata, input hit);
endinterface
`default_nettype wire

// File: inc/acb_params.svh
// Constants for the auxiliary control and configuration block
`ifndef ACB_PARAMS_SVH
`define ACB_PARAMS_SVH
`define ACB_AUX_ADDR    8'hA2
`define ACB_DPL_ADDR    8'h82
`define ACB_DPH_ADDR    8'h83
`define ACB_AUX_RST     8'h00
`define ACB_AUX_WMASK   8'hF3
`define ACB_SOFT_RESET_BIT_BIT    3
`define ACB_ZERO_BIT    2
`define ACB_DPS_BIT     0
`define ACB_PTR_RST     16'h0000
`define ACB_RESET_PC    16'h0000
`define ACB_SIG0_ADDR   16'hFC30
`define ACB_SIG1_ADDR   16'hFC31
`define ACB_SIG2_ADDR   16'hFC60
`define ACB_CUST_FIRST  16'hFCE0
`define ACB_CUST_LAST   16'hFCFF
`define ACB_CFG1_ADDR   16'hFD00
`define ACB_CFG_UNPROG  8'hFF
`define ACB_WATCHDOG_ENABLE_CFG_BIT    7
`define ACB_RPD_BIT     6
`define ACB_CLOCK_RATE_CFG_BIT    3
`define ACB_OSC_HI      2
`define ACB_OSC_LO      0
`define ACB_MC_STD      4'hC
`define ACB_MC_FAST     4'h6
`endif

// File: inc/acb_pkg.sv
// Types shared by the auxiliary control and configuration block
package acb_pkg;
  typedef logic [7:0]  acb_byte_t;
  typedef logic [15:0] acb_addr_t;
  typedef enum logic [2:0] {
    ACB_OSC_HIGH = 3'h0,
    ACB_OSC_MED  = 3'h1,
    ACB_OSC_LOW  = 3'h2,
    ACB_OSC_RC   = 3'h3,
    ACB_OSC_EXT  = 3'h7
  } acb_osc_e;
endpackage

// File: rtl/acb_aux_ctrl.sv
// Auxiliary control register, dual pointers and config byte access
`timescale 1ns/1ps
`default_nettype none
`include "acb_params.svh"
module acb_aux_ctrl
  import acb_pkg::*;
#(
  parameter int CUST_BYTES = 32
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire acb_byte_t   sfr_wdata,
  output acb_byte_t        sfr_rdata,
  output logic             sfr_hit,
  input  wire logic        dp_inc,
  input  wire logic        dp_load,
  input  wire acb_addr_t   dp_load_val,
  input  wire acb_byte_t   acc,
  input  wire logic        jmp_req,
  output acb_addr_t        jmp_target,
  input  wire logic        code_rd,
  output acb_byte_t        code_rdata,
  output logic             code_hit,
  input  wire logic        xdata_rd,
  output acb_byte_t        xdata_rdata,
  output acb_addr_t        xdata_addr,
  output logic             soft_rst_pulse,
  output acb_addr_t        restart_pc,
  input  wire acb_byte_t   cfg_nv_byte,
  output logic             cfg_valid,
  output logic             wdt_enable,
  output logic             rst_pin_disable,
  output logic [3:0]       mc_clocks,
  output acb_osc_e         osc_src,
  output logic             osc_reserved,
  input  wire logic        prog_we,
  input  wire logic [4:0]  prog_addr,
  input  wire acb_byte_t   prog_wdata
);
  acb_byte_t aux_r;
  acb_addr_t data_pointer_r [2];
  acb_addr_t data_pointer_nxt;
  acb_addr_t sel_ptr;
  acb_byte_t cfg_byte_r;
  logic      cfg_done_r;
  logic      soft_rst_r;
  acb_byte_t sfr_rdata_r;
  logic      sfr_hit_r;
  acb_byte_t code_rdata_r;
  logic      code_hit_r;
  acb_byte_t xdata_rdata_r;
  acb_addr_t jmp_target_r;
  logic      pointer_select_bit;
  logic      aux_wr;
  logic      soft_reset_bit_wr;
  logic      dpl_wr;
  logic      dph_wr;

  acb_nv_if nv ();

  function automatic acb_addr_t add_acc(input acb_addr_t p,
                                        input acb_byte_t a);
    add_acc = 16'(p + {8'h00, a});
  endfunction

  function automatic acb_osc_e osc_decode(input logic [2:0] f);
    case (f)
      3'h7:    osc_decode = ACB_OSC_EXT;
      3'h3:    osc_decode = ACB_OSC_RC;
      3'h2:    osc_decode = ACB_OSC_LOW;
      3'h1:    osc_decode = ACB_OSC_MED;
      3'h0:    osc_decode = ACB_OSC_HIGH;
      default: osc_decode = ACB_OSC_EXT;
    endcase
  endfunction

  assign pointer_select_bit     = aux_r[`ACB_DPS_BIT];
  assign sel_ptr = data_pointer_r[pointer_select_bit];
  assign aux_wr  = sfr_wr && (sfr_addr == `ACB_AUX_ADDR);
  assign soft_reset_bit_wr = aux_wr && sfr_wdata[`ACB_SOFT_RESET_BIT_BIT];
  assign dpl_wr  = sfr_wr && (sfr_addr == `ACB_DPL_ADDR);
  assign dph_wr  = sfr_wr && (sfr_addr == `ACB_DPH_ADDR);

  // Aux control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_r <= `ACB_AUX_RST;
    end else if (clk_en) begin
      if (soft_reset_bit_wr) begin
        aux_r <= `ACB_AUX_RST;
      // bits 2 and 3 never stored
      end else if (aux_wr) begin
        aux_r <= sfr_wdata & `ACB_AUX_WMASK;
      end
    end
  end

  always_comb begin
    data_pointer_nxt = sel_ptr;
    if (dp_load) begin
      data_pointer_nxt = dp_load_val;
    end else if (dp_inc) begin
      data_pointer_nxt = 16'(sel_ptr + 16'h0001);
    end else if (dph_wr) begin
      data_pointer_nxt = {sfr_wdata, sel_ptr[7:0]};
    end else if (dpl_wr) begin
      data_pointer_nxt = {sel_ptr[15:8], sfr_wdata};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_pointer_r[0] <= `ACB_PTR_RST;
      data_pointer_r[1] <= `ACB_PTR_RST;
    end else if (clk_en) begin
      if (soft_reset_bit_wr) begin
        data_pointer_r[0] <= `ACB_PTR_RST;
        data_pointer_r[1] <= `ACB_PTR_RST;
      end else begin
        data_pointer_r[pointer_select_bit] <= data_pointer_nxt;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_rst_r <= 1'b0;
    end else if (clk_en) begin
      soft_rst_r <= soft_reset_bit_wr;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata_r <= 8'h00;
      sfr_hit_r   <= 1'b0;
    end else if (clk_en) begin
      sfr_hit_r <= 1'b0;
      if (sfr_rd) begin
        sfr_hit_r <= 1'b1;
        case (sfr_addr)
          `ACB_AUX_ADDR: sfr_rdata_r <= aux_r;
          `ACB_DPL_ADDR: sfr_rdata_r <= sel_ptr[7:0];
          `ACB_DPH_ADDR: sfr_rdata_r <= sel_ptr[15:8];
          default: begin
            sfr_rdata_r <= 8'h00;
            sfr_hit_r   <= 1'b0;
          end
        endcase
      end
    end
  end

  assign nv.rd   = code_rd;
  assign nv.addr = add_acc(sel_ptr, acc);

  acb_nv_store #(
    .CUST_BYTES (CUST_BYTES)
  ) u_store (
    .clk        (clk),
    .clk_en     (clk_en),
    .prog_we    (prog_we),
    .prog_addr  (prog_addr),
    .prog_wdata (prog_wdata),
    .nv         (nv.store)
  );

  // Code read and jump target results
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_rdata_r <= 8'h00;
      code_hit_r   <= 1'b0;
      jmp_target_r <= `ACB_PTR_RST;
    end else if (clk_en) begin
      code_hit_r <= 1'b0;
      if (code_rd) begin
        code_rdata_r <= nv.rdata;
        code_hit_r   <= nv.hit;
      end
      if (jmp_req) begin
        jmp_target_r <= add_acc(sel_ptr, acc);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xdata_rdata_r <= 8'h00;
    end else if (clk_en && xdata_rd) begin
      // config byte one at its address
      if (sel_ptr == `ACB_CFG1_ADDR) begin
        xdata_rdata_r <= cfg_byte_r;
      end else begin
        xdata_rdata_r <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_byte_r <= `ACB_CFG_UNPROG;
      cfg_done_r <= 1'b0;
    end else if (clk_en && !cfg_done_r) begin
      cfg_byte_r <= cfg_nv_byte;
      cfg_done_r <= 1'b1;
    end
  end

  assign sfr_rdata      = sfr_rdata_r;
  assign sfr_hit        = sfr_hit_r;
  assign code_rdata     = code_rdata_r;
  assign code_hit       = code_hit_r;
  assign jmp_target     = jmp_target_r;
  assign xdata_rdata    = xdata_rdata_r;
  assign xdata_addr     = sel_ptr;
  assign soft_rst_pulse = soft_rst_r;
  assign restart_pc     = `ACB_RESET_PC;
  assign cfg_valid      = cfg_done_r;
  assign wdt_enable      = cfg_byte_r[`ACB_WATCHDOG_ENABLE_CFG_BIT];
  assign rst_pin_disable = ~cfg_byte_r[`ACB_RPD_BIT];
  assign mc_clocks = cfg_byte_r[`ACB_CLOCK_RATE_CFG_BIT] ? `ACB_MC_FAST
                                               : `ACB_MC_STD;
  assign osc_src = osc_decode(cfg_byte_r[`ACB_OSC_HI:`ACB_OSC_LO]);
  assign osc_reserved = (cfg_byte_r[`ACB_OSC_HI:`ACB_OSC_LO] > 3'h3) &&
                        (cfg_byte_r[`ACB_OSC_HI:`ACB_OSC_LO] != 3'h7);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_soft_reset_bit;
    clk_en && soft_reset_bit_wr |=> soft_rst_pulse;
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit)
    else $error("soft reset pulse missing");

  property p_soft_reset_bit_clear;
    clk_en && soft_reset_bit_wr |=> aux_r == `ACB_AUX_RST &&
      data_pointer_r[0] == `ACB_PTR_RST && data_pointer_r[1] == `ACB_PTR_RST;
  endproperty
  a_soft_reset_bit_clear: assert property (p_soft_reset_bit_clear)
    else $error("soft reset left state behind");

  property p_dps;
    clk_en && aux_wr && !soft_reset_bit_wr |=> pointer_select_bit == $past(sfr_wdata[0]);
  endproperty
  a_dps: assert property (p_dps)
    else $error("select bit not written");

  property p_hidden;
    clk_en && !soft_reset_bit_wr && !pointer_select_bit |=> data_pointer_r[1] == $past(data_pointer_r[1]);
  endproperty
  a_hidden: assert property (p_hidden)
    else $error("unselected pointer changed");

  property p_inc;
    clk_en && dp_inc && !dp_load && !soft_reset_bit_wr && !aux_wr
      |=> sel_ptr == 16'($past(sel_ptr) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc)
    else $error("pointer increment wrong");

  property p_dph_read;
    clk_en && sfr_rd && sfr_addr == `ACB_DPH_ADDR
      |=> sfr_rdata == $past(sel_ptr[15:8]) && sfr_hit;
  endproperty
  a_dph_read: assert property (p_dph_read)
    else $error("high byte read wrong");

  property p_zero_bits;
    clk_en && sfr_rd && sfr_addr == `ACB_AUX_ADDR
      |=> sfr_rdata[`ACB_ZERO_BIT] == 1'b0 &&
          sfr_rdata[`ACB_SOFT_RESET_BIT_BIT] == 1'b0;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("aux bit 2 or 3 read as one");

  property p_cfg_read;
    clk_en && xdata_rd && sel_ptr == `ACB_CFG1_ADDR
      |=> xdata_rdata == cfg_byte_r;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config byte read wrong");

  property p_cfg_fixed;
    cfg_done_r |=> $stable(cfg_byte_r) && cfg_done_r;
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed)
    else $error("config byte changed after start");

  property p_sig0;
    clk_en && code_rd && nv.addr == `ACB_SIG0_ADDR |=> code_hit;
  endproperty
  a_sig0: assert property (p_sig0)
    else $error("signature read missed");

  property p_mc;
    !cfg_byte_r[`ACB_CLOCK_RATE_CFG_BIT] |-> mc_clocks == 4'hC;
  endproperty
  a_mc: assert property (p_mc)
    else $error("machine cycle length wrong");

  c_soft_reset_bit:   cover property (clk_en && soft_reset_bit_wr ##1 soft_rst_pulse);
  c_toggle: cover property (clk_en && aux_wr && !pointer_select_bit ##1 pointer_select_bit);
  c_cust:   cover property (clk_en && code_rd && nv.hit ##1 code_hit);
  c_cfg:    cover property (clk_en && xdata_rd &&
                            sel_ptr == `ACB_CFG1_ADDR);
endmodule
`default_nettype wire

// File: rtl/acb_nv_store.sv
// Signature bytes and customer byte area in code space
`timescale 1ns/1ps
`default_nettype none
`include "acb_params.svh"
module acb_nv_store
  import acb_pkg::*;
#(
  parameter int        CUST_BYTES = 32,
  // Arbitrary signature values
  parameter acb_byte_t SIG0       = 8'h5A,
  parameter acb_byte_t SIG1       = 8'hA5,
  parameter acb_byte_t SIG2       = 8'h3C
) (
  input  wire logic         clk,
  input  wire logic         clk_en,
  input  wire logic         prog_we,
  input  wire logic [4:0]   prog_addr,
  input  wire acb_byte_t    prog_wdata,
  acb_nv_if.store           nv
);
  acb_byte_t cust_mem_r [CUST_BYTES];

  // Programming port loads customer bytes
  // addressed byte writes, one per enabled clock
  always_ff @(posedge clk) begin
    if (clk_en && prog_we) begin
      cust_mem_r[prog_addr] <= prog_wdata;
    end
  end

  always_comb begin
    nv.rdata = 8'h00;
    nv.hit   = 1'b0;
    if (nv.rd) begin
      case (nv.addr)
        `ACB_SIG0_ADDR: begin
          nv.rdata = SIG0;
          nv.hit   = 1'b1;
        end
        `ACB_SIG1_ADDR: begin
          nv.rdata = SIG1;
          nv.hit   = 1'b1;
        end
        `ACB_SIG2_ADDR: begin
          nv.rdata = SIG2;
          nv.hit   = 1'b1;
        end
        default: begin
          if (nv.addr >= `ACB_CUST_FIRST && nv.addr <= `ACB_CUST_LAST) begin
            nv.rdata = cust_mem_r[nv.addr[4:0]];
            nv.hit   = 1'b1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: test/test_aux_control_and_config_bytes.sv
// Self-checking bench for the auxiliary control and config block
`timescale 1ns/1ps
`default_nettype none
`include "acb_params.svh"
module test_aux_control_and_config_bytes
  import acb_pkg::*;
;
  logic      clk, rstn, clk_en, sfr_wr, sfr_rd, dp_inc, dp_load;
  logic      jmp_req, code_rd, xdata_rd, prog_we;
  logic      sfr_hit, code_hit, soft_rst_pulse, cfg_valid, wdt_enable;
  logic      rst_pin_disable, osc_reserved;
  logic [7:0] sfr_addr;
  logic [4:0] prog_addr;
  logic [3:0] mc_clocks;
  acb_byte_t sfr_wdata, sfr_rdata, acc, code_rdata, xdata_rdata;
  acb_byte_t cfg_nv_byte, prog_wdata;
  acb_addr_t dp_load_val, jmp_target, xdata_addr, restart_pc;
  acb_osc_e  osc_src;
  int        errors, total_checks, dp[2], sel, aux, cfg, cust[32];
  // Arbitrary signature values, as set in the store
  localparam int SIG0 = 8'h5A, SIG1 = 8'hA5, SIG2 = 8'h3C;

  acb_aux_ctrl #(.CUST_BYTES(32)) u_dut (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .dp_inc(dp_inc),
    .dp_load(dp_load), .dp_load_val(dp_load_val), .acc(acc),
    .jmp_req(jmp_req), .jmp_target(jmp_target), .code_rd(code_rd),
    .code_rdata(code_rdata), .code_hit(code_hit), .xdata_rd(xdata_rd),
    .xdata_rdata(xdata_rdata), .xdata_addr(xdata_addr),
    .soft_rst_pulse(soft_rst_pulse), .restart_pc(restart_pc),
    .cfg_nv_byte(cfg_nv_byte), .cfg_valid(cfg_valid),
    .wdt_enable(wdt_enable), .rst_pin_disable(rst_pin_disable),
    .mc_clocks(mc_clocks), .osc_src(osc_src),
    .osc_reserved(osc_reserved), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic model_rst();
    aux = 0;
    sel = 0;
    dp[0] = 0;
    dp[1] = 0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    model_rst();
  endtask

  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1;
    if (a == `ACB_AUX_ADDR && d[3]) model_rst();
    else if (a == `ACB_AUX_ADDR) begin
      aux = d & `ACB_AUX_WMASK;
      sel = aux & 1;
    end
    else if (a == `ACB_DPL_ADDR) dp[sel] = (dp[sel] & 16'hFF00) | d;
    else if (a == `ACB_DPH_ADDR) dp[sel] = (dp[sel] & 16'h00FF) | (d << 8);
  endtask

  task automatic sfr_r(input logic [7:0] a);
    int e;
    int h;
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    h = (a == `ACB_AUX_ADDR || a == `ACB_DPL_ADDR || a == `ACB_DPH_ADDR);
    e = (a == `ACB_AUX_ADDR) ? aux : (a == `ACB_DPL_ADDR) ?
        (dp[sel] & 8'hFF) : (a == `ACB_DPH_ADDR) ? (dp[sel] >> 8) : 0;
    chk("sfr_rdata", e, sfr_rdata);
    chk("sfr_hit", h, sfr_hit);
  endtask

  task automatic ptr_op(input logic inc, input logic ld,
                        input logic [15:0] v);
    @(posedge clk);
    dp_inc <= inc;
    dp_load <= ld;
    dp_load_val <= v;
    @(posedge clk);
    dp_inc <= 1'b0;
    dp_load <= 1'b0;
    #1;
    dp[sel] = ld ? v : inc ? ((dp[sel] + 1) & 16'hFFFF) : dp[sel];
  endtask

  task automatic reads(input logic [7:0] a);
    int ad;
    int h;
    int e;
    @(posedge clk);
    acc <= a;
    code_rd <= 1'b1;
    jmp_req <= 1'b1;
    xdata_rd <= 1'b1;
    @(posedge clk);
    code_rd <= 1'b0;
    jmp_req <= 1'b0;
    xdata_rd <= 1'b0;
    #1;
    ad = (dp[sel] + a) & 16'hFFFF;
    h = (ad == 16'hFC30 || ad == 16'hFC31 || ad == 16'hFC60 ||
         (ad >= 16'hFCE0 && ad <= 16'hFCFF));
    e = !h ? 0 : (ad == 16'hFC30) ? SIG0 : (ad == 16'hFC31) ? SIG1 :
        (ad == 16'hFC60) ? SIG2 : cust[ad - 16'hFCE0];
    chk("jmp_target", ad, jmp_target);
    chk("code_rdata", e, code_rdata);
    chk("code_hit", h, code_hit);
    chk("xdata_rdata", dp[sel] == 16'hFD00 ? cfg : 0, xdata_rdata);
    chk("xdata_addr", dp[sel], xdata_addr);
  endtask

  task automatic cfg_chk();
    chk("cfg_valid", 1, cfg_valid);
    chk("wdt_enable", cfg[7], wdt_enable);
    chk("rst_pin_disable", !cfg[6], rst_pin_disable);
    chk("mc_clocks", cfg[3] ? 6 : 12, mc_clocks);
    chk("osc_src", ((cfg & 7) inside {4, 5, 6}) ? 7 : (cfg & 7),
        osc_src);
    chk("osc_reserved", (cfg & 7) inside {4, 5, 6}, osc_reserved);
  endtask

  initial begin
    #100000;
    errors++;
    results();
  end

  initial begin
    {rstn, sfr_wr, sfr_rd, dp_inc, dp_load, jmp_req} = '0;
    {code_rd, xdata_rd, prog_we, sfr_addr, prog_addr} = '0;
    {sfr_wdata, acc, cfg_nv_byte, prog_wdata, dp_load_val} = '0;
    clk_en = 1'b1;
    errors = 0;
    total_checks = 0;
    void'($urandom(33266));
    for (int k = 0; k < 8; k++) begin
      cfg = ($urandom & 8'hF8) | k;
      cfg_nv_byte <= cfg;
      do_reset();
      cfg_chk();
      sfr_r(`ACB_AUX_ADDR);
      sfr_r(`ACB_DPH_ADDR);
      cfg_nv_byte <= ~cfg;
      ptr_op(0, 1, `ACB_CFG1_ADDR);
      reads(8'h00);
      cfg_chk();
    end
    @(posedge clk);
    prog_we <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      cust[i] = $urandom & 8'hFF;
      prog_addr <= i;
      prog_wdata <= cust[i];
      @(posedge clk);
    end
    prog_we <= 1'b0;
    ptr_op(0, 1, 16'hFC00);
    foreach (cust[i]) reads(8'hE0 + i);
    reads(8'h30);
    reads(8'h31);
    reads(8'h60);
    reads(8'hDF);
    sfr_w(`ACB_AUX_ADDR, 8'hF5);
    sfr_r(`ACB_AUX_ADDR);
    sfr_w(`ACB_AUX_ADDR, 8'h03);
    sfr_w(`ACB_AUX_ADDR, 8'h04);
    sfr_r(`ACB_AUX_ADDR);
    for (int n = 0; n < 80; n++) begin
      case ($urandom % 6)
        0: ptr_op(1, 0, 16'h0000);
        1: ptr_op(0, 1, $urandom);
        2: sfr_w(`ACB_DPL_ADDR, $urandom);
        3: sfr_w(`ACB_DPH_ADDR, $urandom);
        4: sfr_w(`ACB_AUX_ADDR, $urandom & 8'hF7);
        default: begin
          sfr_w(8'h90, $urandom);
          sfr_r(8'h90);
          reads($urandom);
        end
      endcase
      sfr_r(`ACB_DPL_ADDR);
      sfr_r(`ACB_DPH_ADDR);
      sfr_r(`ACB_AUX_ADDR);
    end
    @(posedge clk);
    clk_en <= 1'b0;
    dp_inc <= 1'b1;
    @(posedge clk);
    clk_en <= 1'b1;
    dp_inc <= 1'b0;
    sfr_r(`ACB_DPL_ADDR);
    sfr_w(`ACB_AUX_ADDR, 8'h09);
    chk("soft_rst_pulse", 1, soft_rst_pulse);
    @(posedge clk);
    #1;
    chk("soft_rst_pulse", 0, soft_rst_pulse);
    chk("restart_pc", `ACB_RESET_PC, restart_pc);
    sfr_r(`ACB_AUX_ADDR);
    sfr_r(`ACB_DPL_ADDR);
    sfr_w(`ACB_AUX_ADDR, 8'h01);
    sfr_r(`ACB_DPH_ADDR);
    cfg_chk();
    results();
  end
endmodule
`default_nettype wire
